// >>> core/tsrm_top.sv
// temperature sensor register bank with conversion sequencing and alarms
//
// Contract
// R1: status, result and identification registers are read-only; others writable.
// R2: low flag sets below low limit; clears on status read or above limit+hyst.
// R3: high flag sets above high limit; clears on status read or below limit-hyst.
// R4: critical flag sets above critical limit; clears likewise with hysteresis.
// R5: ready bit goes low on new result, returns high on result read.
// R6: in one-shot or once-per-second mode, a mode write also returns ready high.
// R7: configuration bits 1:0 give one to four faults before alarm.
// R8: configuration bit 2 sets critical alarm pin polarity.
// R9: configuration bit 3 sets limit alarm pin polarity.
// R10: configuration bit 4 picks interrupt or comparator pin behaviour.
// R11: mode 00 restarts conversion as soon as each completes.
// R12: mode 01 performs a single 240 ms conversion.
// R13: mode 10 converts once per second, each conversion 60 ms.
// R14: mode 11 powers down all but the serial register access.
// R15: configuration bit 7 selects 13-bit or 16-bit resolution.
// R16: result register reads as one 16-bit twos complement value.
// R17: at 13 bits result bits 2:0 hold critical, high, low events.
// R18: alarms need consecutive faults; an in-limit conversion resets the count.
// R19: hysteresis is four unsigned bits in 1 degree steps.
// R20: critical pin activates when result exceeds critical limit.
// R21: in interrupt behaviour any register read releases both pins.
// R22: writes to read-only registers are ignored.
// R23: comparisons and flags update once per stored result.
`timescale 1ns/1ps
module tsrm_top
    import tsrm_pkg::*;
#(
    parameter int CONV_CYCLES = CONV_CYC,
    parameter int FAST_CONV_CYCLES = FAST_CONV_CYC,
    parameter int SPS_PERIOD_CYCLES = SPS_PERIOD_CYC
)
(
    // system
    input wire logic SYS_CLK,
    input wire logic RST_B,
    // serial link
    input wire logic SCLK,
    input wire logic CS_B,
    input wire logic DIN,
    output logic DOUT,
    output logic DOUT_OE,
    // converter
    input wire logic [15:0] ADC_CODE,
    output logic ADC_ON,
    // alarm pins
    output logic CRITICAL_ALARM_PIN,
    output logic LIMIT_ALARM_PIN
);
    import tsrm_pkg::*;

    typedef enum logic [1:0] {SEQ_IDLE, SEQ_CONV, SEQ_REST} tsrm_seq_t;

    tsrm_bus_if bus ();

    logic [7:0] status_r, config_r, hyst_r;
    logic [15:0] temp_r, crit_r, high_r, low_r;
    logic [15:0] code_s1, code_s2;
    tsrm_seq_t seq_r;
    logic [TMR_W-1:0] tmr_r;
    logic conv_done, cfg_wr, mode_wr_rdy, any_read;
    logic [15:0] code_m, result_nxt;
    logic signed [16:0] t_s, hyst_s;
    logic below_low, above_high, above_crit;
    logic low_back, high_back, crit_back;
    tsrm_mode_t mode;
    logic [15:0] rdata;

    assign mode = tsrm_mode_t'(config_r[CF_MODE_LO +: 2]);

    // signed compare helpers
    function automatic logic signed [16:0] sx(input logic [15:0] v);
        return {v[15], v};
    endfunction

    // ------------------------------------------------------------------
    // serial front end
    // ------------------------------------------------------------------
    tsrm_spi u_spi (
        .clk(SYS_CLK),
        .rst_b(RST_B),
        .sclk(SCLK),
        .cs_b(CS_B),
        .din(DIN),
        .dout(DOUT),
        .dout_oe(DOUT_OE),
        .bus(bus.link)
    );

    // ------------------------------------------------------------------
    // converter code capture; the code is resampled every cycle through two registers
    // ------------------------------------------------------------------
    always_ff @(posedge SYS_CLK)
    begin
        code_s1 <= ADC_CODE;
        code_s2 <= code_s1;
    end

    // ------------------------------------------------------------------
    // conversion sequencer
    // ------------------------------------------------------------------
    assign cfg_wr = bus.wr && bus.addr == REG_CONFIG;

    always_ff @(posedge SYS_CLK)
    begin
        if (!RST_B)
        begin
            seq_r <= SEQ_CONV;
            tmr_r <= '0;
        end
        else if (cfg_wr)
        begin
            // any mode write restarts timing; shutdown stops it
            tmr_r <= '0;
            if (tsrm_mode_t'(bus.wdata[CF_MODE_LO +: 2]) == MODE_SHUTDOWN) //R14
                seq_r <= SEQ_IDLE;
            else
                seq_r <= SEQ_CONV;
        end
        else
        begin
            unique case (seq_r)
                SEQ_IDLE:
                    tmr_r <= '0;
                SEQ_CONV:
                    if (conv_done)
                    begin
                        unique case (mode)
                            MODE_CONT:
                            begin
                                tmr_r <= '0;
                                seq_r <= SEQ_CONV; //R11
                            end
                            MODE_ONCE_PER_SECOND:
                            begin
                                tmr_r <= tmr_r + 1'b1;
                                seq_r <= SEQ_REST; //R13
                            end
                            default:
                            begin
                                tmr_r <= '0;
                                seq_r <= SEQ_IDLE; //R12
                            end
                        endcase
                    end
                    else
                        tmr_r <= tmr_r + 1'b1;
                SEQ_REST:
                    if (tmr_r == TMR_W'(SPS_PERIOD_CYCLES - 1))
                    begin
                        tmr_r <= '0;
                        seq_r <= SEQ_CONV; //R13
                    end
                    else
                        tmr_r <= tmr_r + 1'b1;
                default:
                    seq_r <= SEQ_IDLE;
            endcase
        end
    end

    // once-per-second conversions are the short kind
    assign conv_done = seq_r == SEQ_CONV && !cfg_wr &&
        tmr_r == TMR_W'((mode == MODE_ONCE_PER_SECOND ? FAST_CONV_CYCLES :
        CONV_CYCLES) - 1); //R12 R13

    always_ff @(posedge SYS_CLK)
    begin
        if (!RST_B)
            ADC_ON <= 1'b1;
        else
            ADC_ON <= mode != MODE_SHUTDOWN; //R14
    end

    // ------------------------------------------------------------------
    // limit comparisons on the fresh code
    // ------------------------------------------------------------------
    // at 13 bits the three low bits are not part of the reading
    assign code_m = config_r[CF_RES16] ? code_s2 :
        {code_s2[15:FLAG_BITS], FLAG_BITS'(0)}; //R15
    assign t_s = sx(code_m);
    assign hyst_s = 17'(hyst_r[3:0]) <<< HYST_SHIFT; //R19
    assign below_low = t_s < sx(low_r);
    assign above_high = t_s > sx(high_r);
    assign above_crit = t_s > sx(crit_r); //R20
    assign low_back = t_s > sx(low_r) + hyst_s; //R19
    assign high_back = t_s < sx(high_r) - hyst_s; //R19
    assign crit_back = t_s < sx(crit_r) - hyst_s;

    assign result_nxt = config_r[CF_RES16] ? code_m :
        {code_m[15:FLAG_BITS], above_crit, above_high, below_low}; //R17

    always_ff @(posedge SYS_CLK)
    begin
        if (!RST_B)
            temp_r <= TEMP_RST;
        else if (conv_done)
            temp_r <= result_nxt; //R16 R23
    end

    // ------------------------------------------------------------------
    // status flags: a hardware set beats a same-cycle clear
    // ------------------------------------------------------------------
    assign any_read = bus.rd;
    assign mode_wr_rdy = cfg_wr && (mode == MODE_ONE_SHOT ||
        mode == MODE_ONCE_PER_SECOND);

    function automatic logic flag_nxt(input logic cur, input logic set,
        input logic back, input logic rd_clr);
        if (set)
            return 1'b1;
        if (back || rd_clr)
            return 1'b0;
        return cur;
    endfunction

    always_ff @(posedge SYS_CLK)
    begin
        logic st_rd;
        st_rd = bus.rd && bus.addr == REG_STATUS;
        if (!RST_B)
            status_r <= STATUS_RST;
        else
        begin
            status_r[ST_LOW] <= flag_nxt(status_r[ST_LOW],
                conv_done && below_low, conv_done && low_back, st_rd); //R2
            status_r[ST_HIGH] <= flag_nxt(status_r[ST_HIGH],
                conv_done && above_high, conv_done && high_back, st_rd); //R3
            status_r[ST_CRIT] <= flag_nxt(status_r[ST_CRIT],
                conv_done && above_crit, conv_done && crit_back, st_rd); //R4
            if (conv_done)
                status_r[ST_RDY] <= 1'b0; //R5
            else if ((bus.rd && bus.addr == REG_TEMP) || mode_wr_rdy)
                status_r[ST_RDY] <= 1'b1; //R5 R6
        end
    end

    // ------------------------------------------------------------------
    // writable registers; writes to read-only addresses fall through
    // ------------------------------------------------------------------
    always_ff @(posedge SYS_CLK)
    begin
        if (!RST_B)
        begin
            config_r <= CONFIG_RST;
            crit_r <= CRIT_RST;
            hyst_r <= HYST_RST;
            high_r <= HIGH_RST;
            low_r <= LOW_RST;
        end
        else if (bus.wr)
        begin
            unique case (bus.addr)
                REG_CONFIG: config_r <= bus.wdata[7:0]; //R1
                REG_CRIT: crit_r <= bus.wdata; //R1
                REG_HYST: hyst_r <= bus.wdata[7:0]; //R1
                REG_HIGH: high_r <= bus.wdata; //R1
                REG_LOW: low_r <= bus.wdata; //R1
                default: ; //R22
            endcase
        end
    end

    // ------------------------------------------------------------------
    // read data
    // ------------------------------------------------------------------
    always_comb
    begin
        unique case (bus.addr)
            REG_STATUS: rdata = {8'h00, status_r};
            REG_CONFIG: rdata = {8'h00, config_r};
            REG_TEMP: rdata = temp_r; //R16
            REG_ID: rdata = {8'h00, MAKER_ID, REVISION_ID};
            REG_CRIT: rdata = crit_r;
            REG_HYST: rdata = {8'h00, hyst_r};
            REG_HIGH: rdata = high_r;
            REG_LOW: rdata = low_r;
        endcase
    end
    assign bus.rdata = rdata;

    // ------------------------------------------------------------------
    // alarm pins
    // ------------------------------------------------------------------
    tsrm_alarm u_crit (
        .clk(SYS_CLK),
        .rst_b(RST_B),
        .conv_done(conv_done),
        .fault(above_crit), //R18 R20
        .back_in(crit_back),
        .queue(config_r[CF_QUEUE_LO +: 2]), //R7
        .pol_high(config_r[CF_CRIT_POL]), //R8
        .cmp_mode(config_r[CF_CMP]), //R10
        .any_read(any_read), //R21
        .pin(CRITICAL_ALARM_PIN)
    );

    tsrm_alarm u_limit (
        .clk(SYS_CLK),
        .rst_b(RST_B),
        .conv_done(conv_done),
        .fault(above_high || below_low), //R18
        // release needs the reading inside both hysteresis bands; a
        // status read clears flags and must not shorten comparator hold
        .back_in(high_back && low_back), //R10 R19
        .queue(config_r[CF_QUEUE_LO +: 2]), //R7
        .pol_high(config_r[CF_LIM_POL]), //R9
        .cmp_mode(config_r[CF_CMP]), //R10
        .any_read(any_read), //R21
        .pin(LIMIT_ALARM_PIN)
    );
endmodule

// >>> include/tsrm_pkg.sv
// constants, register map and types of the temperature sensor register bank
package tsrm_pkg;
    // ------------------------------------------------------------------
    // clock and conversion timing
    // ------------------------------------------------------------------
    localparam int CLK_HZ = 50_000_000;
    localparam int CONV_TIME_MS = 240;
    localparam int FAST_CONV_TIME_MS = 60;
    localparam int SPS_PERIOD_MS = 1000;
    localparam int CONV_CYC = CLK_HZ / 1000 * CONV_TIME_MS;
    localparam int FAST_CONV_CYC = CLK_HZ / 1000 * FAST_CONV_TIME_MS;
    localparam int SPS_PERIOD_CYC = CLK_HZ / 1000 * SPS_PERIOD_MS;
    localparam int TMR_W = 26;

    // ------------------------------------------------------------------
    // register indices and reset values
    // ------------------------------------------------------------------
    localparam logic [2:0] REG_STATUS = 3'h0;
    localparam logic [2:0] REG_CONFIG = 3'h1;
    localparam logic [2:0] REG_TEMP = 3'h2;
    localparam logic [2:0] REG_ID = 3'h3;
    localparam logic [2:0] REG_CRIT = 3'h4;
    localparam logic [2:0] REG_HYST = 3'h5;
    localparam logic [2:0] REG_HIGH = 3'h6;
    localparam logic [2:0] REG_LOW = 3'h7;
    localparam logic [7:0] STATUS_RST = 8'h80;
    localparam logic [7:0] CONFIG_RST = 8'h00;
    localparam logic [15:0] TEMP_RST = 16'h0000;
    localparam logic [15:0] CRIT_RST = 16'h4980;
    localparam logic [7:0] HYST_RST = 8'h05;
    localparam logic [15:0] HIGH_RST = 16'h2000;
    localparam logic [15:0] LOW_RST = 16'h0500;
    // identification values are arbitrary
    localparam logic [4:0] MAKER_ID = 5'h0A;
    localparam logic [2:0] REVISION_ID = 3'h1;

    // ------------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------------
    localparam int ST_LOW = 4;
    localparam int ST_HIGH = 5;
    localparam int ST_CRIT = 6;
    localparam int ST_RDY = 7;
    localparam int CF_QUEUE_LO = 0;
    localparam int CF_CRIT_POL = 2;
    localparam int CF_LIM_POL = 3;
    localparam int CF_CMP = 4;
    localparam int CF_MODE_LO = 5;
    localparam int CF_RES16 = 7;
    localparam int CMD_RD = 6;
    localparam int CMD_ADDR_LO = 3;
    localparam int FLAG_BITS = 3;
    localparam int HYST_SHIFT = 7;
    localparam logic [4:0] CMD_LAST = 5'h07;
    localparam logic [4:0] BYTE_BITS = 5'h08;
    localparam logic [4:0] WORD_BITS = 5'h10;

    typedef enum logic [1:0] {
        MODE_CONT,
        MODE_ONE_SHOT,
        MODE_ONCE_PER_SECOND,
        MODE_SHUTDOWN
    } tsrm_mode_t;

    // 16-bit registers move two bytes on the link, the rest one
    function automatic logic reg_is_wide(input logic [2:0] addr);
        return (addr == REG_TEMP) || (addr == REG_CRIT) ||
            (addr == REG_HIGH) || (addr == REG_LOW);
    endfunction
endpackage

// >>> include/tsrm_bus_if.sv
// register access path between the serial front end and the register bank
`timescale 1ns/1ps
interface tsrm_bus_if;
    logic rd;
    logic wr;
    logic [2:0] addr;
    logic [15:0] wdata;
    logic [15:0] rdata;
    modport link (output rd, output wr, output addr, output wdata,
        input rdata);
    modport regs (input rd, input wr, input addr, input wdata,
        output rdata);
endinterface

// >>> core/tsrm_spi.sv
// serial slave: command byte, then 8 or 16 data bits, MSB first
`timescale 1ns/1ps
module tsrm_spi
    import tsrm_pkg::*;
(
    // system
    input wire logic clk,
    input wire logic rst_b,
    // serial pins
    input wire logic sclk,
    input wire logic cs_b,
    input wire logic din,
    output logic dout,
    output logic dout_oe,
    // register side
    tsrm_bus_if.link bus
);
    logic cs_s1, cs_s2, sclk_s1, sclk_s2, sclk_s3, din_s1, din_s2;
    logic [4:0] cnt_r;
    logic [15:0] shin_r, shout_r;
    logic [2:0] addr_r;
    logic rd_cmd_r, rd_r, wr_r;
    logic [15:0] shin_nxt;
    logic rise, fall, active;

    // ------------------------------------------------------------------
    // synchronisers; the link clock is only sampled, never used as clock
    // ------------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        cs_s1 <= cs_b;
        cs_s2 <= cs_s1;
        sclk_s1 <= sclk;
        sclk_s2 <= sclk_s1;
        sclk_s3 <= sclk_s2;
        din_s1 <= din;
        din_s2 <= din_s1;
    end

    assign rise = sclk_s2 & ~sclk_s3;
    assign fall = ~sclk_s2 & sclk_s3;
    assign active = ~cs_s2;
    assign shin_nxt = {shin_r[14:0], din_s2};

    // ------------------------------------------------------------------
    // receive side: bit count, command decode, request pulses
    // ------------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        rd_r <= 1'b0;
        wr_r <= 1'b0;
        if (!rst_b || !active)
        begin
            cnt_r <= '0;
            rd_cmd_r <= 1'b0;
            if (!rst_b)
            begin
                shin_r <= '0;
                addr_r <= '0;
            end
        end
        else if (rise && cnt_r != '1)
        begin
            shin_r <= shin_nxt;
            cnt_r <= cnt_r + 5'h01;
            if (cnt_r == CMD_LAST)
            begin
                addr_r <= shin_nxt[CMD_ADDR_LO +: 3];
                rd_cmd_r <= shin_nxt[CMD_RD];
                rd_r <= shin_nxt[CMD_RD];
            end
            else if (!rd_cmd_r && cnt_r == CMD_LAST +
                (reg_is_wide(addr_r) ? WORD_BITS : BYTE_BITS))
                wr_r <= 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // transmit side: load on the read pulse, shift on falling edges
    // ------------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            shout_r <= '0;
            dout <= 1'b0;
            dout_oe <= 1'b0;
        end
        else
        begin
            dout_oe <= active && rd_cmd_r;
            if (rd_r)
                shout_r <= reg_is_wide(addr_r) ? bus.rdata :
                    {bus.rdata[7:0], 8'h00};
            else if (fall && active && rd_cmd_r)
            begin
                dout <= shout_r[15];
                shout_r <= {shout_r[14:0], 1'b0};
            end
        end
    end

    assign bus.rd = rd_r;
    assign bus.wr = wr_r;
    assign bus.addr = addr_r;
    assign bus.wdata = reg_is_wide(addr_r) ? shin_r : {8'h00, shin_r[7:0]};
endmodule

// >>> core/tsrm_alarm.sv
// one alarm pin: fault queue, interrupt or comparator behaviour, polarity
`timescale 1ns/1ps
module tsrm_alarm
    import tsrm_pkg::*;
(
    // system
    input wire logic clk,
    input wire logic rst_b,
    // per conversion
    input wire logic conv_done,
    input wire logic fault,
    input wire logic back_in,
    // configuration and host activity
    input wire logic [1:0] queue,
    input wire logic pol_high,
    input wire logic cmp_mode,
    input wire logic any_read,
    // pin
    output logic pin
);
    logic [1:0] fcnt_r;
    logic act_r, act_nxt;
    logic trip;

    assign trip = conv_done && fault && fcnt_r == queue;

    always_ff @(posedge clk)
    begin
        if (!rst_b)
            fcnt_r <= '0;
        else if (conv_done)
        begin
            if (!fault || fcnt_r == queue)
                fcnt_r <= '0;
            else
                fcnt_r <= fcnt_r + 2'h1;
        end
    end

    always_comb
    begin
        act_nxt = act_r;
        if (cmp_mode && conv_done && back_in)
            act_nxt = 1'b0;
        if (!cmp_mode && any_read)
            act_nxt = 1'b0;
        if (trip)
            act_nxt = 1'b1;
    end

    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            act_r <= 1'b0;
            pin <= 1'b1;
        end
        else
        begin
            act_r <= act_nxt;
            pin <= pol_high ? act_nxt : ~act_nxt;
        end
    end
endmodule

// >>> testbench/tsrm_asserts.sv
// concurrent checks on the register bank's top-level ports
`timescale 1ns/1ps
module tsrm_asserts
(
    // system
    input wire logic SYS_CLK,
    input wire logic RST_B,
    // serial link
    input wire logic CS_B,
    input wire logic DOUT_OE,
    // converter and alarms
    input wire logic ADC_ON,
    input wire logic CRITICAL_ALARM_PIN,
    input wire logic LIMIT_ALARM_PIN
);
    default clocking cb @(posedge SYS_CLK);
    endclocking
    default disable iff (!RST_B);

    // --------
    // serial output enable
    // --------
    AST_OE_IDLE: assert property (CS_B [*6] |-> !DOUT_OE)
        else $error("output enable held with chip select high");
    AST_OE_RISE: assert property ($rose(DOUT_OE) |-> !$past(CS_B, 8))
        else $error("output enable rose before a command byte");
    AST_OE_DROP: assert property ($rose(CS_B) |-> ##[1:6] !DOUT_OE)
        else $error("output enable not released after frame");

    // --------
    // power state and pins
    // --------
    AST_ADC_QUIET: assert property (CS_B [*8] |-> $stable(ADC_ON))
        else $error("converter power moved without a write");
    AST_ADC_CHG: assert property ($changed(ADC_ON) |-> !$past(CS_B, 8))
        else $error("converter power moved outside a frame");
    // in shutdown nothing converts, so only host traffic may move a pin
    AST_PIN_HOLD: assert property ((!ADC_ON && CS_B) [*8] |->
        $stable({CRITICAL_ALARM_PIN, LIMIT_ALARM_PIN}))
        else $error("alarm pin moved while powered down");
    AST_RST_OUT: assert property ($rose(RST_B) |-> ADC_ON && !DOUT_OE)
        else $error("wrong converter or enable state after reset");
    AST_RST_PINS: assert property ($rose(RST_B) |->
        CRITICAL_ALARM_PIN && LIMIT_ALARM_PIN)
        else $error("alarm pins not inactive after reset");
endmodule

bind tsrm_top tsrm_asserts u_asserts (.SYS_CLK(SYS_CLK), .RST_B(RST_B),
    .CS_B(CS_B), .DOUT_OE(DOUT_OE), .ADC_ON(ADC_ON),
    .CRITICAL_ALARM_PIN(CRITICAL_ALARM_PIN),
    .LIMIT_ALARM_PIN(LIMIT_ALARM_PIN));

// >>> testbench/tsrm_host.sv
// host model: drives the serial link and reads back register data
`timescale 1ns/1ps
module tsrm_host
(
    // serial pins
    output logic sclk,
    output logic cs_b,
    output logic din,
    input wire logic dout
);
    initial
    begin
        sclk = 1'b1;
        cs_b = 1'b1;
        din = 1'b0;
    end

    // one access per frame; the link clock stands high outside frames
    task automatic xfer(input logic rd, input logic [2:0] a,
        input logic [15:0] wd, output logic [15:0] rv);
        logic [23:0] sh;
        int nb;
        nb = (a inside {3'h2, 3'h4, 3'h6, 3'h7}) ? 24 : 16;
        sh = {1'b0, rd, a, 3'h0, nb == 24 ? wd : {wd[7:0], 8'h00}};
        rv = 16'h0000;
        #13 cs_b = 1'b0;
        #80;
        for (int i = 0; i < nb; i++)
        begin
            sclk = 1'b0;
            din = sh[23 - i];
            #80 sclk = 1'b1;
            // sample late: the device moves its output a few cycles after
            #79 if (i > 7) rv = {rv[14:0], dout};
            #1;
        end
        cs_b = 1'b1;
        din = ~din;
        #400;
    endtask
endmodule

// >>> testbench/tsrm_top_tb.sv
// self-checking bench of the temperature sensor register bank
`timescale 1ns/1ps
module tsrm_top_tb;
    import tsrm_pkg::*;
    localparam int CONV = 3000;
    localparam logic [15:0] ID_VAL = {8'h00, MAKER_ID, REVISION_ID};
    typedef struct {
        logic wr;
        logic [2:0] a;
        logic [15:0] d;
        logic [15:0] e;
    } tsrm_row_t;
    // --------
    // rows: optional write, then a read that must give e
    // --------
    tsrm_row_t rows[16] = '{
        '{1'h0, 3'h0, 16'h0, 16'h0080}, '{1'h0, 3'h1, 16'h0, 16'h0000},
        '{1'h0, 3'h2, 16'h0, 16'h0000}, '{1'h0, 3'h3, 16'h0, ID_VAL},
        '{1'h0, 3'h4, 16'h0, 16'h4980}, '{1'h0, 3'h5, 16'h0, 16'h0005},
        '{1'h0, 3'h6, 16'h0, 16'h2000}, '{1'h0, 3'h7, 16'h0, 16'h0500},
        '{1'h1, 3'h1, 16'h0060, 16'h0060}, '{1'h1, 3'h0, 16'h00FF, 16'h0080},
        '{1'h1, 3'h2, 16'h1234, 16'h0000}, '{1'h1, 3'h3, 16'h00FF, ID_VAL},
        '{1'h1, 3'h4, 16'h3000, 16'h3000}, '{1'h1, 3'h5, 16'h0003, 16'h0003},
        '{1'h1, 3'h6, 16'h1800, 16'h1800}, '{1'h1, 3'h7, 16'h0600, 16'h0600}};
    logic sys_clk;
    logic rst_b;
    logic sclk, cs_b, din, dout, dout_oe, adc_on, crit_pin, lim_pin;
    logic [15:0] adc_code;
    logic [15:0] rv;
    int n_errors = 0;
    int checks = 0;
    int n;
    int m;

    tsrm_top #(.CONV_CYCLES(CONV), .FAST_CONV_CYCLES(300),
        .SPS_PERIOD_CYCLES(1000)) DUT (.SYS_CLK(sys_clk), .RST_B(rst_b),
        .SCLK(sclk), .CS_B(cs_b), .DIN(din), .DOUT(dout), .DOUT_OE(dout_oe),
        .ADC_CODE(adc_code), .ADC_ON(adc_on),
        .CRITICAL_ALARM_PIN(crit_pin), .LIMIT_ALARM_PIN(lim_pin));
    tsrm_host host (.sclk(sclk), .cs_b(cs_b), .din(din), .dout(dout));

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp)
        begin
            n_errors++;
            $display("wrong value at %0t: %h not %h", $time, got, exp);
        end
    endtask

    task automatic rdc(input logic [2:0] a, input logic [15:0] exp);
        host.xfer(1'b1, a, 16'h0000, rv);
        chk(rv, exp);
    endtask

    task automatic wr(input logic [2:0] a, input logic [15:0] d);
        host.xfer(1'b0, a, d, rv);
    endtask

    task automatic wait_pins(input logic [1:0] want, input int lim);
        n = 0;
        while ({crit_pin, lim_pin} !== want && n < lim)
        begin
            @(negedge sys_clk);
            n++;
        end
    endtask

    task automatic stop_test();
        $display("errors %0d checks %0d", n_errors, checks);
        if (n_errors == 0 && checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    initial
    begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end

    // a whole run needs about 1 ms
    initial
    begin
        #1_500_000;
        n_errors++;
        stop_test();
    end

    initial
    begin
        rst_b = 1'b0;
        adc_code = 16'h3100;
        repeat (8) @(negedge sys_clk);
        rst_b = 1'b1;
        repeat (4) @(negedge sys_clk);
        chk(adc_on, 1'b1);
        foreach (rows[i])
        begin
            if (rows[i].wr)
                wr(rows[i].a, rows[i].d);
            rdc(rows[i].a, rows[i].e);
        end
        chk(adc_on, 1'b0);
        // --------
        // over both limits, interrupt behaviour, pins active high
        // --------
        wr(3'h1, 16'h000C);
        wait_pins(2'b11, CONV + 200);
        chk({crit_pin, lim_pin}, 2'b11);
        rdc(3'h0, 16'h0060);
        chk({crit_pin, lim_pin}, 2'b00);
        rdc(3'h2, 16'h3106);
        rdc(3'h0, 16'h0080);
        // --------
        // comparator behaviour, four faults, hysteresis release
        // --------
        wr(3'h1, 16'h0013);
        wait_pins(2'b11, CONV);
        m = n;
        wait_pins(2'b00, 5 * CONV);
        chk(m + n > 3 * CONV && m + n < 4 * CONV + 50, 1'b1);
        rdc(3'h0, 16'h0060);
        chk({crit_pin, lim_pin}, 2'b00);
        @(negedge sys_clk) adc_code = 16'h1700;
        wait_pins(2'b10, 2 * CONV);
        chk({crit_pin, lim_pin}, 2'b10);
        @(negedge sys_clk) adc_code = 16'h1600;
        wait_pins(2'b11, 2 * CONV);
        chk({crit_pin, lim_pin}, 2'b11);
        // --------
        // under the low limit
        // --------
        @(negedge sys_clk) adc_code = 16'h0500;
        wr(3'h1, 16'h0000);
        wait_pins(2'b10, 2 * CONV);
        chk({crit_pin, lim_pin}, 2'b10);
        rdc(3'h0, 16'h0010);
        rdc(3'h2, 16'h0501);
        // --------
        // one-shot: a single conversion, mode write returns ready
        // --------
        @(negedge sys_clk) adc_code = 16'h0800;
        wr(3'h1, 16'h0020);
        repeat (CONV + 100) @(negedge sys_clk);
        rdc(3'h0, 16'h0000);
        wr(3'h1, 16'h0020);
        rdc(3'h0, 16'h0080);
        repeat (CONV + 100) @(negedge sys_clk);
        rdc(3'h2, 16'h0800);
        repeat (2 * CONV) @(negedge sys_clk);
        rdc(3'h0, 16'h0080);
        // --------
        // 16-bit result, then a reset in mid-run
        // --------
        @(negedge sys_clk) adc_code = 16'h0805;
        wr(3'h1, 16'h0080);
        repeat (CONV + 100) @(negedge sys_clk);
        rdc(3'h2, 16'h0805);
        wr(3'h1, 16'h00C0);
        repeat (400) @(negedge sys_clk);
        rdc(3'h0, 16'h0000);
        rdc(3'h2, 16'h0805);
        repeat (700) @(negedge sys_clk);
        rdc(3'h0, 16'h0000);
        wr(3'h1, 16'h00C0);
        rdc(3'h0, 16'h0080);
        @(negedge sys_clk) rst_b = 1'b0;
        repeat (8) @(negedge sys_clk);
        rst_b = 1'b1;
        repeat (4) @(negedge sys_clk);
        rdc(3'h1, 16'h0000);
        rdc(3'h4, 16'h4980);
        stop_test();
    end
endmodule
